// ===== vphp_pkg.sv
package vphp_pkg;
  // Clock and port timing
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned READ_HOLD_PS = 8500;
  localparam int unsigned READ_HOLD_CYC =
    (READ_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DATA_LEAD_PS = 22000;
  localparam int unsigned DATA_LEAD_CYC =
    (DATA_LEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] HOLD_LAST = 2'(READ_HOLD_CYC - 1);
  localparam logic [1:0] LEAD_LAST = 2'(DATA_LEAD_CYC - 1);

  // Widths and rate buffer geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned PTR_W = 6;
  localparam int unsigned BUF_NIBBLES = 36;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam logic [5:0] LAST_LOC = 6'h23;
  localparam logic [5:0] PTR_RST = 6'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Port address map
  localparam logic [2:0] ADDR_RX_DATA = 3'h0;
  localparam logic [2:0] ADDR_TX_DATA = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_RX_PTR = 3'h3;

  // Status byte fields
  localparam int unsigned STAT_FULL_BIT = 0;
  localparam int unsigned STAT_EMPTY_BIT = 1;
  localparam int unsigned STAT_WRPTR_LSB = 2;

  typedef enum logic [2:0] {
    S_IDLE, S_RD_LEAD, S_RD_ACT, S_HOLD, S_WR_WAIT, S_WR_ACT
  } vphp_state_t;
endpackage : vphp_pkg

// ===== vphp_fifo_if.sv
`timescale 1ns/1ps
interface vphp_fifo_if #(parameter int unsigned WIDTH = 4);
  logic inValid;
  logic inReady;
  logic [WIDTH-1:0] inData;
  logic outValid;
  logic outReady;
  logic [WIDTH-1:0] outData;
  modport fifo (input inValid, input inData, input outReady,
    output inReady, output outValid, output outData);
  modport user (output inValid, output inData, output outReady,
    input inReady, input outValid, input outData);
endinterface : vphp_fifo_if

// ===== vphp_fifo.sv
`timescale 1ns/1ps
module vphp_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic srst,
  vphp_fifo_if.fifo bus
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign bus.inReady = (count_q != (AW+1)'(DEPTH));
  assign bus.outValid = (count_q != '0);
  assign bus.outData = mem[rdPtr_q];
  assign push = bus.inValid && bus.inReady;
  assign pop = bus.outValid && bus.outReady;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= bus.inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_level_a: assert property (@(posedge clk) disable iff (srst)
    count_q <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule : vphp_fifo

// ===== vphp_top.sv
`timescale 1ns/1ps
// What this block does
// - Slave port: address, strobe, direction, data, ready
// - Read sends to processor, write receives
// - Ready held high while more time needed
// - Write data captured at strobe rise
// - Drive after strobe falls, hold, release
// - Read data valid before ready asserts
// - Clock output derived from master clock
// - Receive reads return nibbles in order
// - Transmit writes fill successive buffer locations
// - 36-nibble buffers wrap circularly
module vphp_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] voicePortAddr,
  input wire logic [7:0] voicePortDataIn,
  output logic [7:0] voicePortDataOut,
  output logic voicePortDataOe,
  input wire logic voicePortStrobeN,
  input wire logic voicePortReadNotWrite,
  output logic voicePortReadyN,
  output logic processorClockOut,
  input wire logic rxNibbleValid,
  input wire logic [3:0] rxNibble,
  input wire logic txFetch,
  input wire logic [5:0] txReadAddr,
  output logic [3:0] txReadData
);
  vphp_pkg::vphp_state_t state_q;
  logic strobeLow_q;
  logic [7:0] dataIn_q;
  logic [2:0] addr_q;
  logic rnw_q;
  logic [1:0] cnt_q;
  logic [5:0] rxWrPtr_q;
  logic [5:0] rxRdPtr_q;
  logic [5:0] txWrPtr_q;
  logic [3:0] rxMem [vphp_pkg::BUF_NIBBLES];
  logic [3:0] txMem [vphp_pkg::BUF_NIBBLES];
  logic strobeFall;
  logic strobeRise;
  logic rxAdvance;
  logic [7:0] readMux;
  logic [7:0] statusByte;

  vphp_fifo_if #(.WIDTH(vphp_pkg::NIB_W)) fifoBus ();

  vphp_fifo #(.WIDTH(vphp_pkg::NIB_W), .DEPTH(vphp_pkg::FIFO_DEPTH)) txFifo (
    .clk(clk),
    .srst(srst),
    .bus(fifoBus)
  );

  function automatic logic [5:0] nextLoc(input logic [5:0] p);
    nextLoc = (p == vphp_pkg::LAST_LOC) ? vphp_pkg::PTR_RST : p + 6'h01;
  endfunction : nextLoc

  // Strobe edges and write data sampling
  assign strobeFall = !voicePortStrobeN && !strobeLow_q;
  assign strobeRise = voicePortStrobeN && strobeLow_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      strobeLow_q <= 1'b0;
      dataIn_q <= vphp_pkg::DATA_RST;
    end else begin
      strobeLow_q <= !voicePortStrobeN;
      dataIn_q <= voicePortDataIn;
    end
  end

  // Status byte and read source selection
  always_comb begin
    statusByte = '0;
    statusByte[vphp_pkg::STAT_FULL_BIT] = !fifoBus.inReady;
    statusByte[vphp_pkg::STAT_EMPTY_BIT] = !fifoBus.outValid;
    statusByte[vphp_pkg::STAT_WRPTR_LSB +: 6] = rxWrPtr_q;
    unique case (voicePortAddr)
      vphp_pkg::ADDR_RX_DATA: readMux = {4'h0, rxMem[rxRdPtr_q]};
      vphp_pkg::ADDR_STATUS: readMux = statusByte;
      vphp_pkg::ADDR_RX_PTR: readMux = {2'h0, rxRdPtr_q};
      default: readMux = '0;
    endcase
  end

  // Access sequencer: ready, bus enable and wait states
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= vphp_pkg::S_IDLE;
      voicePortReadyN <= 1'b1;
      voicePortDataOe <= 1'b0;
      cnt_q <= '0;
      addr_q <= '0;
      rnw_q <= 1'b0;
    end else begin
      unique case (state_q)
        vphp_pkg::S_IDLE: begin
          if (strobeFall) begin
            addr_q <= voicePortAddr;
            rnw_q <= voicePortReadNotWrite;
            cnt_q <= '0;
            if (voicePortReadNotWrite) begin
              voicePortDataOe <= 1'b1;
              state_q <= vphp_pkg::S_RD_LEAD;
            end else if (fifoBus.inReady) begin
              voicePortReadyN <= 1'b0;
              state_q <= vphp_pkg::S_WR_ACT;
            end else begin
              state_q <= vphp_pkg::S_WR_WAIT;
            end
          end
        end
        vphp_pkg::S_RD_LEAD: begin
          cnt_q <= cnt_q + 2'h1;
          if (cnt_q == vphp_pkg::LEAD_LAST) begin
            voicePortReadyN <= 1'b0;
            state_q <= vphp_pkg::S_RD_ACT;
          end
        end
        vphp_pkg::S_RD_ACT: begin
          if (voicePortStrobeN) begin
            voicePortReadyN <= 1'b1;
            cnt_q <= '0;
            state_q <= vphp_pkg::S_HOLD;
          end
        end
        vphp_pkg::S_HOLD: begin
          cnt_q <= cnt_q + 2'h1;
          if (cnt_q == vphp_pkg::HOLD_LAST) begin
            voicePortDataOe <= 1'b0;
            rnw_q <= 1'b0;
            state_q <= vphp_pkg::S_IDLE;
          end
        end
        vphp_pkg::S_WR_WAIT: begin
          if (fifoBus.inReady) begin
            voicePortReadyN <= 1'b0;
            state_q <= vphp_pkg::S_WR_ACT;
          end
        end
        vphp_pkg::S_WR_ACT: begin
          if (voicePortStrobeN) begin
            voicePortReadyN <= 1'b1;
            state_q <= vphp_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // Read data latched at strobe fall, stable to release
  always_ff @(posedge clk) begin
    if (srst) begin
      voicePortDataOut <= vphp_pkg::DATA_RST;
    end else if (state_q == vphp_pkg::S_IDLE && strobeFall) begin
      voicePortDataOut <= readMux;
    end
  end

  // Write nibble pushed at strobe rise
  assign fifoBus.inValid = (state_q == vphp_pkg::S_WR_ACT) &&
    voicePortStrobeN && (addr_q == vphp_pkg::ADDR_TX_DATA);
  assign fifoBus.inData = dataIn_q[3:0];
  assign fifoBus.outReady = !txFetch;

  // Receive buffer: demodulator fills, port drains in order
  assign rxAdvance = (state_q == vphp_pkg::S_RD_ACT) && voicePortStrobeN &&
    (addr_q == vphp_pkg::ADDR_RX_DATA);
  always_ff @(posedge clk) begin
    if (rxNibbleValid) begin
      rxMem[rxWrPtr_q] <= rxNibble;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rxWrPtr_q <= vphp_pkg::PTR_RST;
      rxRdPtr_q <= vphp_pkg::PTR_RST;
    end else begin
      if (rxNibbleValid) begin
        rxWrPtr_q <= nextLoc(rxWrPtr_q);
      end
      if (rxAdvance) begin
        rxRdPtr_q <= nextLoc(rxRdPtr_q);
      end
    end
  end

  // Transmit buffer: fifo drains to successive locations
  always_ff @(posedge clk) begin
    if (fifoBus.outValid && fifoBus.outReady) begin
      txMem[txWrPtr_q] <= fifoBus.outData;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      txWrPtr_q <= vphp_pkg::PTR_RST;
    end else if (fifoBus.outValid && fifoBus.outReady) begin
      txWrPtr_q <= nextLoc(txWrPtr_q);
    end
  end

  // Modulator read port
  always_ff @(posedge clk) begin
    if (srst) begin
      txReadData <= 4'h0;
    end else if (txReadAddr <= vphp_pkg::LAST_LOC) begin
      txReadData <= txMem[txReadAddr];
    end else begin
      txReadData <= 4'h0;
    end
  end

  // Processor clock at half the master rate
  always_ff @(posedge clk) begin
    if (srst) begin
      processorClockOut <= 1'b0;
    end else begin
      processorClockOut <= !processorClockOut;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  read_lead_a: assert property (
    (state_q == vphp_pkg::S_RD_LEAD && $fell(voicePortReadyN)) or
    ($fell(voicePortReadyN) && rnw_q) |->
    $past(voicePortDataOe, 3)) else $error("ready before read data led");
  bus_only_read_a: assert property (
    voicePortDataOe |-> rnw_q) else $error("bus driven outside a read");
  read_release_a: assert property (
    state_q == vphp_pkg::S_RD_ACT && voicePortStrobeN |=>
    voicePortDataOe ##1 !voicePortDataOe)
    else $error("read hold or release wrong");
  read_drive_a: assert property (
    state_q == vphp_pkg::S_IDLE && strobeFall && voicePortReadNotWrite |=>
    voicePortDataOe && voicePortReadyN [*3] ##1 !voicePortReadyN)
    else $error("read not driven after strobe fall");
  write_wait_a: assert property (
    state_q == vphp_pkg::S_WR_WAIT |-> voicePortReadyN)
    else $error("ready while fifo full");
  write_capture_a: assert property (
    fifoBus.inValid |-> fifoBus.inReady && $past(!voicePortStrobeN) &&
    fifoBus.inData == $past(voicePortDataIn[3:0]))
    else $error("write data not taken at strobe rise");
  rx_order_a: assert property (
    rxAdvance |=> rxRdPtr_q == (($past(rxRdPtr_q) == vphp_pkg::LAST_LOC) ?
    6'h00 : $past(rxRdPtr_q) + 6'h01)) else $error("rx order broken");
  wrap_range_a: assert property (
    txWrPtr_q <= vphp_pkg::LAST_LOC && rxWrPtr_q <= vphp_pkg::LAST_LOC)
    else $error("buffer pointer past last location");
  clk_out_a: assert property (
    !$past(srst) |-> processorClockOut != $past(processorClockOut))
    else $error("processor clock not toggling");

  read_done_c: cover property (state_q == vphp_pkg::S_HOLD);
  write_done_c: cover property (fifoBus.inValid);
  write_wait_c: cover property (state_q == vphp_pkg::S_WR_WAIT ##1
    state_q == vphp_pkg::S_WR_ACT);
  rx_wrap_c: cover property (rxAdvance && rxRdPtr_q == vphp_pkg::LAST_LOC);
endmodule : vphp_top

// ===== vphp_host_model.sv
`timescale 1ns/1ps
module vphp_host_model (
  input wire logic clk,
  output logic strobeN,
  output logic readNotWrite,
  output logic [2:0] addr,
  output logic [7:0] dataOut,
  input wire logic readyN,
  input wire logic [7:0] busData,
  input wire logic busOe
);
  // Idle bus: strobe high, own data drive only a changing pattern
  initial begin
    strobeN = 1'b1;
    readNotWrite = 1'b1;
    addr = 3'h0;
    dataOut = 8'h5a;
  end

  // One access; strobe low until ready sampled low, plus slow cycles
  task automatic access(input logic rnw, input logic [2:0] a,
      input logic [7:0] d, input int slow, output logic [7:0] q,
      output logic ok);
    int n;
    @(negedge clk);
    readNotWrite = rnw;
    addr = a;
    dataOut = rnw ? ~dataOut : d;
    strobeN = 1'b0;
    n = 0;
    @(posedge clk);
    while (readyN !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    q = busData;
    ok = (n < 50);
    repeat (slow) @(posedge clk);
    @(negedge clk);
    strobeN = 1'b1;
    // Address and data held one more cycle past the strobe rise
    @(negedge clk);
    addr = ~a;
    dataOut = ~dataOut;
    n = 0;
    while (busOe !== 1'b0 && n < 8) begin
      n++;
      @(negedge clk);
    end
    if (n >= 8) begin
      ok = 1'b0;
    end
  endtask : access
endmodule : vphp_host_model

// ===== vphp_top_test.sv
`timescale 1ns/1ps
module vphp_top_test;
  logic clk, srst, strobeN, rnw, readyN, processor_clock_out, dataOe, rxValid;
  logic txFetch, ok, prevClk;
  logic [2:0] addr;
  logic [7:0] hostData, busIn, dataOut, q, d;
  logic [3:0] rxNib, txData;
  logic [5:0] txAddr;
  int error_cnt = 0;
  int checks = 0;
  int rxCnt = 0;
  int seed;
  logic [3:0] rxQ[$];
  logic [3:0] txMem[36];

  // Wire level of the shared data bus
  assign busIn = dataOe ? dataOut : hostData;

  vphp_top uut (.clk(clk), .srst(srst), .voicePortAddr(addr),
    .voicePortDataIn(busIn), .voicePortDataOut(dataOut),
    .voicePortDataOe(dataOe), .voicePortStrobeN(strobeN),
    .voicePortReadNotWrite(rnw), .voicePortReadyN(readyN),
    .processorClockOut(processor_clock_out), .rxNibbleValid(rxValid),
    .rxNibble(rxNib), .txFetch(txFetch), .txReadAddr(txAddr),
    .txReadData(txData));

  vphp_host_model host (.clk(clk), .strobeN(strobeN),
    .readNotWrite(rnw), .addr(addr), .dataOut(hostData),
    .readyN(readyN), .busData(busIn), .busOe(dataOe));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [7:0] ptrOf(input int n);
    return {2'h0, 6'(n % 36)};
  endfunction : ptrOf

  task automatic xfer(input logic r, input logic [2:0] a, input int slow);
    host.access(r, a, d, slow, q, ok);
    chk({7'h0, ok}, 8'h01);
    if (ok !== 1'b1) begin
      report_and_stop();
    end
  endtask : xfer

  task automatic pushRx(input int n);
    repeat (n) begin
      @(negedge clk);
      rxNib = 4'($urandom);
      rxValid = 1'b1;
      rxQ.push_back(rxNib);
      rxCnt++;
    end
    @(negedge clk);
    rxValid = 1'b0;
  endtask : pushRx

  task automatic pullRx(input int n);
    repeat (n) begin
      xfer(1'b1, vphp_pkg::ADDR_RX_DATA, $urandom_range(2));
      chk(q, {4'h0, rxQ.pop_front()});
    end
    xfer(1'b1, vphp_pkg::ADDR_RX_PTR, 0);
    chk(q, ptrOf(rxCnt));
    xfer(1'b1, vphp_pkg::ADDR_STATUS, 0);
    chk({2'h0, q[7:2]}, ptrOf(rxCnt));
  endtask : pullRx

  task automatic checkTx();
    int n;
    n = 0;
    q = 8'h00;
    while (q[vphp_pkg::STAT_EMPTY_BIT] !== 1'b1 && n < 20) begin
      xfer(1'b1, vphp_pkg::ADDR_STATUS, 0);
      n++;
    end
    chk({7'h0, q[vphp_pkg::STAT_EMPTY_BIT]}, 8'h01);
    for (int i = 0; i < 36; i++) begin
      @(negedge clk);
      txAddr = 6'(i);
      @(negedge clk);
      chk({4'h0, txData}, {4'h0, txMem[i]});
    end
  endtask : checkTx

  // Main sequence
  initial begin
    seed = $urandom(32'h4815);
    srst = 1'b1;
    rxValid = 1'b0;
    rxNib = 4'h0;
    txFetch = 1'b0;
    txAddr = 6'h00;
    d = 8'h00;
    repeat (2) @(negedge clk);
    chk(dataOut, 8'h00);
    chk({readyN, dataOe, processor_clock_out, txData, 1'b0}, 8'h80);
    @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    prevClk = processor_clock_out;
    @(negedge clk);
    chk({7'h0, processor_clock_out}, {7'h0, ~prevClk});
    pushRx(30);
    pullRx(30);
    pushRx(12);
    pullRx(12);
    for (int a = 1; a < 8; a++) begin
      if (a == 1 || a > 3) begin
        xfer(1'b1, 3'(a), 0);
        chk(q, 8'h00);
      end
    end
    for (int i = 0; i < 40; i++) begin
      d = 8'($urandom);
      xfer(1'b0, vphp_pkg::ADDR_TX_DATA, $urandom_range(2));
      txMem[i % 36] = d[3:0];
    end
    d = 8'h0f;
    xfer(1'b0, 3'h5, 0);
    checkTx();
    txFetch = 1'b1;
    for (int i = 40; i < 45; i++) begin
      d = 8'($urandom);
      txMem[i % 36] = d[3:0];
      if (i < 44) begin
        xfer(1'b0, vphp_pkg::ADDR_TX_DATA, 0);
      end
    end
    fork
      xfer(1'b0, vphp_pkg::ADDR_TX_DATA, 0);
      begin
        repeat (8) @(negedge clk);
        chk({7'h0, readyN}, 8'h01);
        txFetch = 1'b0;
      end
    join
    checkTx();
    // Mid-run chip reset, held as long as the host must
    srst = 1'b1;
    repeat (18) @(negedge clk);
    chk(dataOut, 8'h00);
    chk({readyN, dataOe, processor_clock_out, txData, 1'b0}, 8'h80);
    srst = 1'b0;
    xfer(1'b1, vphp_pkg::ADDR_RX_PTR, 0);
    chk(q, 8'h00);
    xfer(1'b1, vphp_pkg::ADDR_STATUS, 0);
    chk(q, 8'(1 << vphp_pkg::STAT_EMPTY_BIT));
    report_and_stop();
  end

  // Watchdog
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : vphp_top_test
